// file: design/sltm_pkg.sv
// constants and register map of the serial link test and error monitor
package sltm_pkg;
   localparam int LANES = 8;
   localparam int ADDR_W = 12;
   // register offsets
   localparam logic [11:0] ADDR_LINK_SELECT = 12'h300;
   localparam logic [11:0] ADDR_LANE_TEST_ENABLE = 12'h315;
   localparam logic [11:0] ADDR_LANE_TEST_CONTROL = 12'h316;
   localparam logic [11:0] ADDR_LIMIT_LOW = 12'h317;
   localparam logic [11:0] ADDR_LIMIT_MID = 12'h318;
   localparam logic [11:0] ADDR_LIMIT_HIGH = 12'h319;
   localparam logic [11:0] ADDR_TOTAL_LOW = 12'h31A;
   localparam logic [11:0] ADDR_TOTAL_MID = 12'h31B;
   localparam logic [11:0] ADDR_TOTAL_HIGH = 12'h31C;
   localparam logic [11:0] ADDR_PASS_FLAGS = 12'h31D;
   localparam logic [11:0] ADDR_SAMPLE_CONTROL = 12'h32C;
   localparam logic [11:0] ADDR_EXPECTED_LOW = 12'h32D;
   localparam logic [11:0] ADDR_EXPECTED_HIGH = 12'h32E;
   localparam logic [11:0] ADDR_SAMPLE_RESULT = 12'h32F;
   localparam logic [11:0] ADDR_COUNT_VIEW = 12'h46B;
   localparam logic [11:0] ADDR_DISPARITY_STATUS = 12'h46D;
   localparam logic [11:0] ADDR_BAD_CODE_STATUS = 12'h46E;
   localparam logic [11:0] ADDR_STRAY_CONTROL_STATUS = 12'h46F;
   localparam logic [11:0] ADDR_CGS_FLAGS = 12'h470;
   localparam logic [11:0] ADDR_ALIGN_FLAGS = 12'h473;
   localparam logic [11:0] ADDR_TEST_OPTIONS = 12'h477;
   localparam logic [11:0] ADDR_CHAR_LIMIT = 12'h47C;
   // field positions
   localparam int LINK_SEL_BIT = 2;
   localparam int CHECKER_CLEAR_BIT = 0;
   localparam int TEST_RUN_BIT = 1;
   localparam int PATTERN_LSB = 2;
   localparam int COUNT_LANE_LSB = 4;
   localparam int TPL_ENABLE_BIT = 0;
   localparam int TPL_CLEAR_BIT = 1;
   localparam int CONV_SEL_LSB = 2;
   localparam int SAMPLE_SEL_LSB = 4;
   localparam int VIEW_LANE_LSB = 4;
   localparam int VIEW_TYPE_LSB = 0;
   localparam int INT_CLEAR_BIT = 7;
   localparam int COUNT_DISABLE_BIT = 6;
   localparam int COUNT_CLEAR_BIT = 5;
   localparam int ACTION_LANE_LSB = 0;
   localparam int ILAS_REPEAT_BIT = 7;
   // encodings and counts
   localparam logic [1:0] PATTERN_SHORT = 2'h0;
   localparam logic [1:0] PATTERN_MID = 2'h1;
   localparam logic [1:0] PATTERN_LONG = 2'h2;
   localparam logic [1:0] TYPE_DISPARITY = 2'h0;
   localparam logic [1:0] TYPE_BAD_CODE = 2'h1;
   localparam logic [1:0] TYPE_STRAY_CONTROL = 2'h2;
   localparam logic [23:0] TOTAL_MAX = 24'hFFFFFF;
   localparam logic [4:0] SEED_BITS = 5'h1F;
   localparam logic [2:0] CGS_CHARS = 3'h4;
   localparam logic [2:0] LINK1_LANE_OFFSET = 3'h4;
   localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// file: design/sltm_top.sv
// lane bit checker, sample checker, link status and character error counters
// Behaviour
// - pattern select picks 7, 15 or 31-stage sequence
// - checker runs on raw lanes, several at once
// - enable bit n enables lane n check
// - checker clear pulse zeroes checker state and counts
// - run rising edge starts, writing zero stops
// - 24-bit error threshold from three byte registers
// - one pass flag per lane, 1 is pass
// - lane selector shows saturating 24-bit count
// - compare selected converter sample to expected value
// - expected 16-bit sample in two writable bytes
// - transport clear pulse restarts the comparison
// - result bit 0 is 1 on mismatch
// - test option bit enables repeated alignment mode
// - sync request drops after 4 sync characters
// - sync and alignment flags shown per selected link
// - disparity counter counts bad disparity characters while enabled and below the limit
// - view register selects lane and type, returns count
// - link 1 lane x is logical lane x+4
// - shared limit stops every character error counter
// - per-type status register reports limit reached
// - status write: lane, irq clear, disable, count clear
module sltm_top
(
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [7:0] lane_bit_i,
   input wire logic [255:0] sample_data_i,
   input wire logic sample_valid_i,
   input wire logic [7:0] lane_in_use_i,
   input wire logic [7:0] lane_char_valid_i,
   input wire logic [7:0] lane_k28_i,
   input wire logic [7:0] lane_align_ok_i,
   input wire logic [7:0] disparity_err_i,
   input wire logic [7:0] bad_code_err_i,
   input wire logic [7:0] stray_control_err_i,
   output logic sync_request_output_o,
   output logic ilas_repeat_o
);
   typedef struct packed {
      logic [7:0] link_select;
      logic [7:0] lane_test_enable;
      logic [7:0] lane_test_control;
      logic [23:0] lane_error_limit;
      logic running;
      logic [7:0] sample_check_control;
      logic [15:0] expected_sample;
      logic transport_check_mismatch;
      logic [7:0] char_error_count_view;
      logic [7:0] char_error_limit;
      logic [7:0] link_test_options;
      logic [7:0][30:0] shift;
      logic [7:0][4:0] seed;
      logic [7:0][23:0] lane_error_total;
      logic [2:0][7:0][7:0] char_count;
      logic [2:0][7:0] count_disable;
      logic [2:0][7:0] limit_reached;
      logic [7:0][2:0] k_count;
      logic [7:0] cgs;
      logic [7:0] align;
      logic sync_request;
      logic ilas_repeat;
      logic [7:0] rdata;
   } sltm_state_t;

   sltm_state_t st;
   sltm_state_t next_st;
   logic [7:0] predicted;
   logic [1:0] pattern;
   logic wr_ctrl;
   logic [3:0] sample_index;
   logic [15:0] selected_sample;
   logic [2:0] view_lane;
   logic [7:0] pass_flags;
   logic [7:0][2:0] err_in;

   assign pattern = st.lane_test_control[sltm_pkg::PATTERN_LSB +: 2];
   assign wr_ctrl = reg_wr_i && reg_addr_i == sltm_pkg::ADDR_LANE_TEST_CONTROL;
   assign sample_index = {st.sample_check_control[sltm_pkg::CONV_SEL_LSB +: 2],
                          st.sample_check_control[sltm_pkg::SAMPLE_SEL_LSB +: 2]};
   assign selected_sample = sample_data_i[{sample_index, 4'h0} +: 16];
   assign view_lane = 3'(st.char_error_count_view[sltm_pkg::VIEW_LANE_LSB +: 3]
                      + (st.link_select[sltm_pkg::LINK_SEL_BIT] ? sltm_pkg::LINK1_LANE_OFFSET : 3'h0));

   // per-lane sequence prediction and pass flag
   for (genvar g = 0; g < sltm_pkg::LANES; g++)
   begin : g_lane
      always_comb
      begin
         case (pattern)
            sltm_pkg::PATTERN_SHORT: predicted[g] = st.shift[g][6] ^ st.shift[g][5];
            sltm_pkg::PATTERN_MID: predicted[g] = st.shift[g][14] ^ st.shift[g][13];
            default: predicted[g] = st.shift[g][30] ^ st.shift[g][27];
         endcase
      end
      assign pass_flags[g] = st.lane_test_enable[g] && st.lane_error_total[g] <= st.lane_error_limit;
      assign err_in[g] = {stray_control_err_i[g], bad_code_err_i[g], disparity_err_i[g]};
   end

   always_comb
   begin
      logic [2:0] act_lane;
      logic clear_checker;
      next_st = st;
      act_lane = 3'(reg_wdata_i[sltm_pkg::ACTION_LANE_LSB +: 3]
                 + (st.link_select[sltm_pkg::LINK_SEL_BIT] ? sltm_pkg::LINK1_LANE_OFFSET : 3'h0));
      clear_checker = st.lane_test_control[sltm_pkg::CHECKER_CLEAR_BIT];

      // lane bit checker
      for (int n = 0; n < sltm_pkg::LANES; n++)
      begin
         if (clear_checker)
         begin
            next_st.shift[n] = '0;
            next_st.seed[n] = '0;
            next_st.lane_error_total[n] = '0;
         end
         else if (st.lane_test_enable[n])
         begin
            next_st.shift[n] = {st.shift[n][29:0], lane_bit_i[n]};
            if (st.seed[n] != sltm_pkg::SEED_BITS)
               next_st.seed[n] = 5'(st.seed[n] + 5'h1);
            else if (st.running && lane_bit_i[n] != predicted[n]
                     && st.lane_error_total[n] != sltm_pkg::TOTAL_MAX)
               next_st.lane_error_total[n] = 24'(st.lane_error_total[n] + 24'h1);
         end
      end

      // code group sync and lane alignment
      for (int n = 0; n < sltm_pkg::LANES; n++)
      begin
         if (!lane_in_use_i[n])
         begin
            next_st.k_count[n] = '0;
            next_st.cgs[n] = 1'b0;
         end
         else if (lane_char_valid_i[n] && !st.cgs[n])
         begin
            if (!lane_k28_i[n])
               next_st.k_count[n] = '0;
            else if (3'(st.k_count[n] + 3'h1) == sltm_pkg::CGS_CHARS)
               next_st.cgs[n] = 1'b1;
            else
               next_st.k_count[n] = 3'(st.k_count[n] + 3'h1);
         end
      end
      next_st.align = lane_align_ok_i & lane_in_use_i;
      next_st.sync_request = (st.cgs & lane_in_use_i) != lane_in_use_i || lane_in_use_i == 8'h00;
      next_st.ilas_repeat = st.link_test_options[sltm_pkg::ILAS_REPEAT_BIT];

      // character error counters
      for (int t = 0; t < 3; t++)
      begin
         for (int n = 0; n < sltm_pkg::LANES; n++)
         begin
            if (err_in[n][t] && !st.count_disable[t][n]
                && st.char_count[t][n] < st.char_error_limit)
               next_st.char_count[t][n] = 8'(st.char_count[t][n] + 8'h1);
            if (reg_wr_i && reg_addr_i == 12'(sltm_pkg::ADDR_DISPARITY_STATUS + 12'(t)) && act_lane == 3'(n))
            begin
               next_st.count_disable[t][n] = reg_wdata_i[sltm_pkg::COUNT_DISABLE_BIT];
               if (reg_wdata_i[sltm_pkg::COUNT_CLEAR_BIT])
                  next_st.char_count[t][n] = '0;
               if (reg_wdata_i[sltm_pkg::INT_CLEAR_BIT])
                  next_st.limit_reached[t][n] = 1'b0;
            end
            // set wins over clear
            if (st.char_count[t][n] == st.char_error_limit && st.char_error_limit != 8'h00)
               next_st.limit_reached[t][n] = 1'b1;
         end
      end

      // transport sample check
      if (st.sample_check_control[sltm_pkg::TPL_CLEAR_BIT])
         next_st.transport_check_mismatch = 1'b0;
      else if (st.sample_check_control[sltm_pkg::TPL_ENABLE_BIT] && sample_valid_i
               && selected_sample != st.expected_sample)
         next_st.transport_check_mismatch = 1'b1;

      // register writes
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            sltm_pkg::ADDR_LINK_SELECT: next_st.link_select = reg_wdata_i;
            sltm_pkg::ADDR_LANE_TEST_ENABLE: next_st.lane_test_enable = reg_wdata_i;
            sltm_pkg::ADDR_LANE_TEST_CONTROL: next_st.lane_test_control = reg_wdata_i;
            sltm_pkg::ADDR_LIMIT_LOW: next_st.lane_error_limit[7:0] = reg_wdata_i;
            sltm_pkg::ADDR_LIMIT_MID: next_st.lane_error_limit[15:8] = reg_wdata_i;
            sltm_pkg::ADDR_LIMIT_HIGH: next_st.lane_error_limit[23:16] = reg_wdata_i;
            sltm_pkg::ADDR_SAMPLE_CONTROL: next_st.sample_check_control = reg_wdata_i;
            sltm_pkg::ADDR_EXPECTED_LOW: next_st.expected_sample[7:0] = reg_wdata_i;
            sltm_pkg::ADDR_EXPECTED_HIGH: next_st.expected_sample[15:8] = reg_wdata_i;
            sltm_pkg::ADDR_COUNT_VIEW: next_st.char_error_count_view = reg_wdata_i;
            sltm_pkg::ADDR_TEST_OPTIONS: next_st.link_test_options = reg_wdata_i;
            sltm_pkg::ADDR_CHAR_LIMIT: next_st.char_error_limit = reg_wdata_i;
            default: ;
         endcase
      end
      // start only on a rising edge of the run bit
      if (wr_ctrl)
      begin
         if (!reg_wdata_i[sltm_pkg::TEST_RUN_BIT])
            next_st.running = 1'b0;
         else if (!st.lane_test_control[sltm_pkg::TEST_RUN_BIT])
            next_st.running = 1'b1;
      end

      // read data, one cycle after the strobe
      next_st.rdata = sltm_pkg::RESET_BYTE;
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            sltm_pkg::ADDR_LINK_SELECT: next_st.rdata = st.link_select;
            sltm_pkg::ADDR_LANE_TEST_ENABLE: next_st.rdata = st.lane_test_enable;
            sltm_pkg::ADDR_LANE_TEST_CONTROL: next_st.rdata = st.lane_test_control;
            sltm_pkg::ADDR_LIMIT_LOW: next_st.rdata = st.lane_error_limit[7:0];
            sltm_pkg::ADDR_LIMIT_MID: next_st.rdata = st.lane_error_limit[15:8];
            sltm_pkg::ADDR_LIMIT_HIGH: next_st.rdata = st.lane_error_limit[23:16];
            sltm_pkg::ADDR_TOTAL_LOW:
               next_st.rdata = st.lane_error_total[st.lane_test_control[sltm_pkg::COUNT_LANE_LSB +: 3]][7:0];
            sltm_pkg::ADDR_TOTAL_MID:
               next_st.rdata = st.lane_error_total[st.lane_test_control[sltm_pkg::COUNT_LANE_LSB +: 3]][15:8];
            sltm_pkg::ADDR_TOTAL_HIGH:
               next_st.rdata = st.lane_error_total[st.lane_test_control[sltm_pkg::COUNT_LANE_LSB +: 3]][23:16];
            sltm_pkg::ADDR_PASS_FLAGS: next_st.rdata = pass_flags;
            sltm_pkg::ADDR_SAMPLE_CONTROL: next_st.rdata = st.sample_check_control;
            sltm_pkg::ADDR_EXPECTED_LOW: next_st.rdata = st.expected_sample[7:0];
            sltm_pkg::ADDR_EXPECTED_HIGH: next_st.rdata = st.expected_sample[15:8];
            sltm_pkg::ADDR_SAMPLE_RESULT: next_st.rdata = {7'h00, st.transport_check_mismatch};
            sltm_pkg::ADDR_COUNT_VIEW:
               next_st.rdata = (st.char_error_count_view[sltm_pkg::VIEW_TYPE_LSB +: 2] == 2'h3) ? 8'h00 :
                  st.char_count[st.char_error_count_view[sltm_pkg::VIEW_TYPE_LSB +: 2]][view_lane];
            sltm_pkg::ADDR_DISPARITY_STATUS: next_st.rdata = st.limit_reached[sltm_pkg::TYPE_DISPARITY];
            sltm_pkg::ADDR_BAD_CODE_STATUS: next_st.rdata = st.limit_reached[sltm_pkg::TYPE_BAD_CODE];
            sltm_pkg::ADDR_STRAY_CONTROL_STATUS: next_st.rdata = st.limit_reached[sltm_pkg::TYPE_STRAY_CONTROL];
            sltm_pkg::ADDR_CGS_FLAGS:
               next_st.rdata = st.link_select[sltm_pkg::LINK_SEL_BIT] ? {4'h0, st.cgs[7:4]} : st.cgs;
            sltm_pkg::ADDR_ALIGN_FLAGS:
               next_st.rdata = st.link_select[sltm_pkg::LINK_SEL_BIT] ? {4'h0, st.align[7:4]} : st.align;
            sltm_pkg::ADDR_TEST_OPTIONS: next_st.rdata = st.link_test_options;
            sltm_pkg::ADDR_CHAR_LIMIT: next_st.rdata = st.char_error_limit;
            default: next_st.rdata = sltm_pkg::RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         st <= '0;
         st.sync_request <= 1'b1;
      end
      else
         st <= next_st;
   end

   assign reg_rdata_o = st.rdata;
   assign sync_request_output_o = st.sync_request;
   assign ilas_repeat_o = st.ilas_repeat;

   // checks
   property p_run_start;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      wr_ctrl && reg_wdata_i[1] && !st.lane_test_control[1] |=> st.running;
   endproperty
   a_run_start: assert property (p_run_start) else $error("run did not start on rising edge");

   property p_run_stop;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      wr_ctrl && !reg_wdata_i[1] |=> !st.running ##1 !st.running || st.lane_test_control[1];
   endproperty
   a_run_stop: assert property (p_run_stop) else $error("run did not stop");

   property p_clear;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      st.lane_test_control[0] |=> st.lane_error_total == '0 && st.seed == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("checker clear left counts");

   property p_hold;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      !st.running && !st.lane_test_control[0] |=> $stable(st.lane_error_total);
   endproperty
   a_hold: assert property (p_hold) else $error("lane count changed while stopped");

   property p_saturate;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      st.lane_error_total[0] == 24'hFFFFFF && !st.lane_test_control[0] |=> st.lane_error_total[0] == 24'hFFFFFF;
   endproperty
   a_saturate: assert property (p_saturate) else $error("lane count wrapped");

   property p_char_stop;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      st.char_count[2][5] >= st.char_error_limit && !reg_wr_i |=> st.char_count[2][5] == $past(st.char_count[2][5]);
   endproperty
   a_char_stop: assert property (p_char_stop) else $error("error counter passed the limit");

   property p_reach;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      st.char_count[1][5] == st.char_error_limit && st.char_error_limit != 8'h00 |=> st.limit_reached[1][5];
   endproperty
   a_reach: assert property (p_reach) else $error("limit reached flag missing");

   property p_sync;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      lane_in_use_i != 8'h00 && (st.cgs & lane_in_use_i) == lane_in_use_i |=> !sync_request_output_o;
   endproperty
   a_sync: assert property (p_sync) else $error("sync request not released");

   property p_mismatch;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      st.sample_check_control[0] && !st.sample_check_control[1] && sample_valid_i
      && selected_sample != st.expected_sample |=> st.transport_check_mismatch ##1
      (st.transport_check_mismatch || $past(st.sample_check_control[sltm_pkg::TPL_CLEAR_BIT]));
   endproperty
   a_mismatch: assert property (p_mismatch) else $error("sample mismatch not reported");

   property p_seed_quiet;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      st.seed[1] != sltm_pkg::SEED_BITS |=> $stable(st.lane_error_total[1]);
   endproperty
   a_seed_quiet: assert property (p_seed_quiet) else $error("count moved while seeding");

   property p_disabled;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      st.count_disable[0][5] && !reg_wr_i |=> $stable(st.char_count[0][5]);
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled counter moved");

   property p_ilas;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      st.link_test_options[sltm_pkg::ILAS_REPEAT_BIT] |=> ilas_repeat_o;
   endproperty
   a_ilas: assert property (p_ilas) else $error("repeat mode output missing");

   property p_zero_limit;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      st.char_error_limit == 8'h00 && !reg_wr_i |=> $stable(st.limit_reached);
   endproperty
   a_zero_limit: assert property (p_zero_limit) else $error("flag changed with zero limit");

   property p_pass_flag;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      reg_rd_i && reg_addr_i == sltm_pkg::ADDR_PASS_FLAGS && st.lane_test_enable[1]
      && st.lane_error_total[1] > st.lane_error_limit |=> !reg_rdata_o[1];
   endproperty
   a_pass_flag: assert property (p_pass_flag) else $error("failing lane read as pass");

   property p_align;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      lane_align_ok_i[0] && lane_in_use_i[0] && !lane_in_use_i[5]
      |=> st.align[0] && !st.align[5];
   endproperty
   a_align: assert property (p_align) else $error("alignment flag wrong");

   c_lane_error: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) st.running ##1 st.lane_error_total[1] != '0);
   c_sync_done: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) $fell(sync_request_output_o));
   c_limit: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) $rose(st.limit_reached[2][5]));
   c_mismatch: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      $rose(st.transport_check_mismatch));
   c_disabled: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      st.count_disable[0][5] && disparity_err_i[5]);
endmodule // sltm_top

// file: tb/sltm_tx_model.sv
// link transmitter model: prbs lanes and unique sample slots
module sltm_tx_model
(
   input wire logic clk_sys_i,
   input wire logic [1:0] pat_i,
   input wire logic flip_i,
   output logic [7:0] lane_bit_o,
   output logic [255:0] sample_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [30:0] hist = 31'h5A5A1234;
   logic nb;
   always_comb
   begin
      nb = hist[6] ^ hist[5];
      if (pat_i == 2'h1)
         nb = hist[14] ^ hist[13];
      if (pat_i == 2'h2)
         nb = hist[30] ^ hist[27];
   end
   // lane 1 carries a single bit error when asked
   always_ff @(posedge clk_sys_i)
   begin
      hist <= {hist[29:0], nb};
      lane_bit_o <= {8{nb}} ^ {6'h00, flip_i, 1'b0};
   end
   always_comb
      for (int k = 0; k < 16; k++)
         sample_data_o[k*16 +: 16] = 16'hC300 + 16'(k);
endmodule // sltm_tx_model

// file: tb/sltm_top_bench.sv
// self-checking bench of the serial link test and error monitor
module sltm_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [11:0] reg_addr_i = 12'h000;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [7:0] lane_bit_i;
   logic [255:0] sample_data_i;
   logic [7:0] char_v = 8'h00;
   logic [7:0] char_k = 8'h00;
   logic [7:0] err_ev [3] = '{8'h00, 8'h00, 8'h00};
   logic sync_o;
   logic ilas_o;
   logic [1:0] pat = 2'h0;
   logic flip = 1'b0;
   logic s_valid = 1'b1;
   logic [31:0] lfsr = 32'hEF7B1B8C;
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   sltm_top uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .lane_bit_i(lane_bit_i), .sample_data_i(sample_data_i), .sample_valid_i(s_valid),
      .lane_in_use_i(8'h0F), .lane_char_valid_i(char_v), .lane_k28_i(char_k), .lane_align_ok_i(8'hA5),
      .disparity_err_i(err_ev[0]), .bad_code_err_i(err_ev[1]), .stray_control_err_i(err_ev[2]),
      .sync_request_output_o(sync_o), .ilas_repeat_o(ilas_o));
   sltm_tx_model tx (.clk_sys_i(clk_sys_i), .pat_i(pat), .flip_i(flip), .lane_bit_o(lane_bit_i),
      .sample_data_o(sample_data_i));
   always #4 clk_sys_i = ~clk_sys_i;
   function automatic logic [31:0] lfsr_next(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         err_count++;
         give_verdict();
      end
   end
   task automatic check(logic [23:0] seen, logic [23:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task automatic wr(logic [11:0] a, logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(logic [11:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1;
      d = reg_rdata_o;
   endtask
   task automatic rc(logic [11:0] a, logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      check({16'h0000, d}, {16'h0000, e});
   endtask
   task automatic chars(int n, logic [7:0] k);
      repeat (n)
      begin
         @(posedge clk_sys_i);
         char_v <= 8'h0F;
         char_k <= k;
      end
      @(posedge clk_sys_i);
      char_v <= 8'h00;
   endtask
   // n error events on logical lane 5 per call
   task automatic hit(int t, int n);
      repeat (n)
      begin
         @(posedge clk_sys_i);
         err_ev[t] <= 8'h20;
         @(posedge clk_sys_i);
         err_ev[t] <= 8'h00;
      end
   endtask
   initial
   begin
      logic [23:0] tot;
      logic [3:0] sel;
      int n [3];
      tick(6);
      sys_rst_i <= 1'b0;
      rc(sltm_pkg::ADDR_LANE_TEST_CONTROL, sltm_pkg::RESET_BYTE);
      rc(12'h123, 8'h00);
      check(24'(sync_o), 24'h000001);
      $display("test reset done");
      for (int p = 0; p < 3; p++)
      begin
         pat <= 2'(p);
         wr(sltm_pkg::ADDR_LANE_TEST_ENABLE, 8'h03);
         wr(sltm_pkg::ADDR_LIMIT_LOW, 8'(11 + p));
         wr(sltm_pkg::ADDR_LIMIT_MID, 8'h00);
         wr(sltm_pkg::ADDR_LIMIT_HIGH, 8'h00);
         wr(sltm_pkg::ADDR_LANE_TEST_CONTROL, {4'h0, 2'(p), 2'h1});
         wr(sltm_pkg::ADDR_LANE_TEST_CONTROL, {4'h0, 2'(p), 2'h0});
         tick(40);
         wr(sltm_pkg::ADDR_LANE_TEST_CONTROL, {4'h0, 2'(p), 2'h2});
         for (int f = 0; f < 5; f++)
         begin
            tick(60);
            if (f == 4)
               wr(sltm_pkg::ADDR_LANE_TEST_CONTROL, {4'h1, 2'(p), 2'h0});
            flip <= 1'b1;
            tick(1);
            flip <= 1'b0;
         end
         tick(40);
         for (int b = 0; b < 3; b++)
            rd(sltm_pkg::ADDR_TOTAL_LOW + 12'(b), tot[b*8 +: 8]);
         check(tot, 24'h00000C);
         rc(sltm_pkg::ADDR_PASS_FLAGS, (p == 0) ? 8'h01 : 8'h03);
         wr(sltm_pkg::ADDR_LANE_TEST_CONTROL, {4'h0, 2'(p), 2'h0});
         rc(sltm_pkg::ADDR_TOTAL_LOW, 8'h00);
      end
      $display("test lane checker done");
      for (int c = 0; c < 2; c++)
      begin
         lfsr = lfsr_next(lfsr);
         sel = lfsr[3:0];
         wr(sltm_pkg::ADDR_SAMPLE_CONTROL, {2'h0, sel[1:0], sel[3:2], 2'h1});
         wr(sltm_pkg::ADDR_EXPECTED_LOW, {4'h0, sel} ^ 8'(c));
         wr(sltm_pkg::ADDR_EXPECTED_HIGH, 8'hC3);
         wr(sltm_pkg::ADDR_SAMPLE_CONTROL, {2'h0, sel[1:0], sel[3:2], 2'h3});
         wr(sltm_pkg::ADDR_SAMPLE_CONTROL, {2'h0, sel[1:0], sel[3:2], 2'h1});
         tick(3);
         rc(sltm_pkg::ADDR_SAMPLE_RESULT, 8'(c));
      end
      s_valid <= 1'b0;
      wr(sltm_pkg::ADDR_SAMPLE_CONTROL, {2'h0, sel[1:0], sel[3:2], 2'h3});
      wr(sltm_pkg::ADDR_SAMPLE_CONTROL, {2'h0, sel[1:0], sel[3:2], 2'h1});
      tick(3);
      rc(sltm_pkg::ADDR_SAMPLE_RESULT, 8'h00);
      s_valid <= 1'b1;
      tick(2);
      rc(sltm_pkg::ADDR_SAMPLE_RESULT, 8'h01);
      $display("test sample checker done");
      chars(3, 8'h0F);
      chars(1, 8'h00);
      tick(4);
      check(24'(sync_o), 24'h000001);
      chars(4, 8'h0F);
      tick(2);
      #1;
      check(24'(sync_o), 24'h000000);
      rc(sltm_pkg::ADDR_CGS_FLAGS, 8'h0F);
      rc(sltm_pkg::ADDR_ALIGN_FLAGS, 8'hA5 & 8'h0F);
      wr(sltm_pkg::ADDR_LINK_SELECT, 8'h04);
      rc(sltm_pkg::ADDR_CGS_FLAGS, 8'h00);
      rc(sltm_pkg::ADDR_ALIGN_FLAGS, 8'h00);
      wr(sltm_pkg::ADDR_TEST_OPTIONS, 8'h80);
      tick(1);
      #1;
      check(24'(ilas_o), 24'h000001);
      $display("test link status done");
      wr(sltm_pkg::ADDR_CHAR_LIMIT, 8'h03);
      for (int t = 0; t < 3; t++)
      begin
         lfsr = lfsr_next(lfsr);
         n[t] = 2 + t + int'(lfsr[0]);
         hit(t, n[t]);
      end
      for (int t = 0; t < 3; t++)
      begin
         wr(sltm_pkg::ADDR_COUNT_VIEW, {6'h04, 2'(t)});
         rc(sltm_pkg::ADDR_COUNT_VIEW, 8'((n[t] < 3) ? n[t] : 3));
         rc(sltm_pkg::ADDR_DISPARITY_STATUS + 12'(t), (n[t] >= 3) ? 8'h20 : 8'h00);
      end
      wr(sltm_pkg::ADDR_COUNT_VIEW, 8'h13);
      rc(sltm_pkg::ADDR_COUNT_VIEW, 8'h00);
      wr(sltm_pkg::ADDR_DISPARITY_STATUS, 8'hE1);
      hit(0, 2);
      wr(sltm_pkg::ADDR_COUNT_VIEW, 8'h10);
      rc(sltm_pkg::ADDR_COUNT_VIEW, 8'h00);
      rc(sltm_pkg::ADDR_DISPARITY_STATUS, 8'h00);
      wr(sltm_pkg::ADDR_DISPARITY_STATUS, 8'h01);
      hit(0, 1);
      rc(sltm_pkg::ADDR_COUNT_VIEW, 8'h01);
      wr(sltm_pkg::ADDR_STRAY_CONTROL_STATUS, 8'h21);
      wr(sltm_pkg::ADDR_STRAY_CONTROL_STATUS, 8'h81);
      rc(sltm_pkg::ADDR_STRAY_CONTROL_STATUS, 8'h00);
      $display("test character counters done");
      give_verdict();
   end
endmodule // sltm_top_bench
